// ### sim/tb_uart_autobaud_wake_break.sv
// Bench: device and remote node joined over the serial link
`timescale 1ns/1ns
`include "uabw_defs.svh"
module tb_uart_autobaud_wake_break;
   typedef struct packed {logic [1:0] cfg; logic [15:0] bitlen; logic [15:0] tick;} uabw_row_t;
   localparam int TX_BIT = 8;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel_d = 1'b0;
   logic        psel_n = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic        sleep_mode = 1'b0;
   logic [31:0] d_prdata, n_prdata, rd;
   logic        d_ready, n_ready, d_err, n_err, rx_flag, wake_async, er;
   logic [23:0] bits;
   int          bad_count = 0;
   int          num_checks = 0;
   int          cyc = 0;
   // Cfg is {high speed, wide}; tick is pclk per counter step
   uabw_row_t   rows [4] = '{'{2'b00, 16'h0280, 16'h0200}, '{2'b10, 16'h1040, 16'h0080},
                             '{2'b01, 16'h00A0, 16'h0080}, '{2'b11, 16'h0040, 16'h0020}};

   uabw_link_if link ();
   uabw_dev uabw_dev_i (.pclk(pclk), .presetn(presetn), .psel(psel_d), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(d_prdata), .pready(d_ready),
      .pslverr(d_err), .sleep_mode(sleep_mode), .rx_flag(rx_flag), .wake_async(wake_async),
      .link(link));
   uabw_node uabw_node_i (.pclk(pclk), .presetn(presetn), .psel(psel_n), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(n_prdata), .pready(n_ready),
      .pslverr(n_err), .link(link));
   uabw_checker #(.TX_BIT(TX_BIT)) uabw_checker_i (.pclk(pclk), .presetn(presetn),
      .rx_line(link.rx_line), .tx_line(link.tx_line), .sleep_mode(sleep_mode),
      .rx_flag(rx_flag), .wake_async(wake_async));

   always #5 pclk = ~pclk;

   // ****************************************
   // Tasks
   // ****************************************
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Both slaves share one bus; s picks the node
   task automatic apb(input logic s, input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel_n <= s;
      psel_d <= !s;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while ((s ? n_ready : d_ready) !== 1'b1)
         @(posedge pclk);
      rd = s ? n_prdata : d_prdata;
      er = s ? n_err : d_err;
      psel_n <= 1'b0;
      psel_d <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic node_idle();
      rd = 32'h00000001;
      while (rd[0] !== 1'b0)
         apb(1'b1, 1'b0, `UABW_NODE_STAT, 32'h00000000);
   endtask : node_idle

   task automatic measure(input logic [15:0] tick, input logic [15:0] bitlen);
      logic [15:0] exp;
      exp = 16'h0001 + 16'((bitlen * 16'h0008) / tick);
      while (rx_flag !== 1'b1)
         @(posedge pclk);
      apb(1'b0, 1'b0, `UABW_DEV_DIV, 32'h00000000);
      chk(32'((rd[15:0] >= exp - 16'h0001) && (rd[15:0] <= exp + 16'h0001)), 32'h1);
      apb(1'b0, 1'b0, `UABW_DEV_CTRL, 32'h00000000);
      chk(32'({rd[`UABW_B_RIF], rd[`UABW_B_IDLE], rd[`UABW_B_OVF],
               rd[`UABW_B_CAL]}), 32'hC);
      apb(1'b0, 1'b0, `UABW_DEV_RXDATA, 32'h00000000);
      @(posedge pclk);
      chk(32'(rx_flag), 32'h0);
      apb(1'b0, 1'b1, `UABW_DEV_CTRL, 32'h00000000);
      node_idle();
   endtask : measure

   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 95000)
      begin
         bad_count++;
         finish_test();
      end
   end

   // ****************************************
   // Sequence
   // ****************************************
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(32'({rx_flag, wake_async, link.tx_line, link.rx_line}), 32'h3);
      apb(1'b0, 1'b0, `UABW_DEV_DIV, 32'h00000000);
      chk(rd, 32'(`UABW_DIV_RST));
      apb(1'b1, 1'b0, `UABW_NODE_BIT, 32'h00000000);
      chk(rd, 32'(`UABW_NODE_BIT_RST));
      apb(1'b0, 1'b0, 12'h010, 32'h00000000);
      chk(32'({er, rd[0]}), 32'h2);
      $display("reset test done");
      foreach (rows[i])
      begin
         apb(1'b1, 1'b1, `UABW_NODE_BIT, {16'h0000, rows[i].bitlen});
         apb(1'b0, 1'b1, `UABW_DEV_CTRL, {26'h0000000, rows[i].cfg, 4'h1});
         apb(1'b1, 1'b1, `UABW_NODE_CMD, 32'h00005501);
         measure(rows[i].tick, rows[i].bitlen);
         $display("autobaud row %0d done", i);
      end
      // Start bit cleared about three bits into the sync byte
      apb(1'b1, 1'b1, `UABW_NODE_BIT, 32'h00000040);
      apb(1'b0, 1'b1, `UABW_DEV_CTRL, 32'h00000031);
      apb(1'b1, 1'b1, `UABW_NODE_CMD, 32'h00005501);
      repeat (200) @(posedge pclk);
      apb(1'b0, 1'b1, `UABW_DEV_CTRL, 32'h00000030);
      node_idle();
      apb(1'b0, 1'b0, `UABW_DEV_CTRL, 32'h00000000);
      chk(32'({rd[`UABW_B_RIF], rd[`UABW_B_IDLE], rd[`UABW_B_CAL]}), 32'h2);
      $display("abort test done");
      // Break then preloaded sync byte, bit time 8 pclk
      apb(1'b0, 1'b1, `UABW_DEV_DIV, 32'h00000001);
      apb(1'b0, 1'b1, `UABW_DEV_CTRL, 32'h0000003C);
      apb(1'b0, 1'b1, `UABW_DEV_TXDATA, 32'h000000FF);
      while (link.tx_line !== 1'b0)
         @(posedge pclk);
      fork
         apb(1'b0, 1'b1, `UABW_DEV_TXDATA, 32'h00000055);
         begin
            repeat (TX_BIT / 2) @(posedge pclk);
            for (int i = 0; i < 24; i++)
            begin
               bits[i] = link.tx_line;
               repeat (TX_BIT) @(posedge pclk);
            end
         end
      join
      // One idle bit: the preloaded byte waits for the next bit tick
      chk(32'(bits), 32'h00556000);
      apb(1'b0, 1'b0, `UABW_DEV_CTRL, 32'h00000000);
      chk(32'(rd[`UABW_B_BRK]), 32'h0);
      chk(32'(rd[`UABW_B_IDLE]), 32'h1);
      $display("break test done");
      apb(1'b0, 1'b1, `UABW_DEV_CTRL, 32'h00000002);
      apb(1'b1, 1'b1, `UABW_NODE_BIT, 32'h00000010);
      sleep_mode <= 1'b1;
      apb(1'b1, 1'b1, `UABW_NODE_CMD, 32'h000D0002);
      while (link.rx_line !== 1'b0)
         @(posedge pclk);
      chk(32'(wake_async), 32'h1);
      node_idle();
      apb(1'b1, 1'b1, `UABW_NODE_CMD, 32'h00005501);
      node_idle();
      sleep_mode <= 1'b0;
      apb(1'b0, 1'b0, `UABW_DEV_CTRL, 32'h00000000);
      chk(32'({rd[`UABW_B_RIF], rd[`UABW_B_WAKE]}), 32'h2);
      apb(1'b0, 1'b0, `UABW_DEV_RXDATA, 32'h00000000);
      @(posedge pclk);
      chk(32'(rx_flag), 32'h0);
      // Measure must skip the break and take the sync byte
      apb(1'b1, 1'b1, `UABW_NODE_BIT, 32'h00000040);
      apb(1'b0, 1'b1, `UABW_DEV_CTRL, 32'h00000033);
      apb(1'b1, 1'b1, `UABW_NODE_CMD, 32'h000D0002);
      node_idle();
      apb(1'b0, 1'b0, `UABW_DEV_RXDATA, 32'h00000000);
      apb(1'b1, 1'b1, `UABW_NODE_CMD, 32'h00005501);
      measure(16'h0020, 16'h0040);
      $display("wake test done");
      finish_test();
   end
endmodule : tb_uart_autobaud_wake_break

// ### sim/uabw_checker.sv
// Concurrent checks on the serial link and the device flags
`timescale 1ns/1ns
module uabw_checker
#(
   parameter int TX_BIT = 8
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Link and flags
   input wire logic rx_line,
   input wire logic tx_line,
   input wire logic sleep_mode,
   input wire logic rx_flag,
   input wire logic wake_async
);
   // ****************************************
   // Run lengths of the transmit line, wake aftermath
   // ****************************************
   logic [15:0] lo_ff;
   logic [15:0] hi_ff;
   logic [2:0]  wk_ff;
   logic        wa_ff;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lo_ff <= 16'h0000;
         hi_ff <= 16'h0000;
         wk_ff <= 3'h0;
         wa_ff <= 1'b0;
      end
      else
      begin
         lo_ff <= tx_line ? 16'h0000 : lo_ff + 16'h0001;
         hi_ff <= !tx_line ? 16'h0000 : hi_ff + {15'h0000, hi_ff != 16'hFFFF};
         wa_ff <= wake_async;
         // Settle margin covers the receive synchroniser
         if (!sleep_mode)
            wk_ff <= 3'h0;
         else if (rx_line && wa_ff)
            wk_ff <= 3'h1;
         else if (wk_ff != 3'h0 && wk_ff != 3'h7)
            wk_ff <= wk_ff + 3'h1;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_wake_event;
      $fell(rx_line) && wake_async;
   endsequence

   a_link_idle_reset: assert property ($rose(presetn) |-> rx_line && tx_line)
      else $error("link not idle after reset");
   a_flag_clear_reset: assert property ($rose(presetn) |-> !rx_flag && !wake_async)
      else $error("flags set after reset");
   a_wake_async_cause: assert property (wake_async |-> sleep_mode && !rx_line)
      else $error("wake output without low line in sleep");
   a_wake_sets_flag: assert property (s_wake_event |-> ##[1:5] rx_flag)
      else $error("wake event did not raise receive flag");
   a_wake_once: assert property (wk_ff == 3'h7 |-> !wake_async)
      else $error("wake still armed after break ended");
   a_break_low_grid: assert property ($rose(tx_line) |-> lo_ff % TX_BIT == 0)
      else $error("low run not whole bits");
   a_break_low_len: assert property ($rose(tx_line) |->
      lo_ff <= 9 * TX_BIT || lo_ff == 13 * TX_BIT)
      else $error("low run of wrong length");
   a_stop_bit_min: assert property ($fell(tx_line) |-> hi_ff >= TX_BIT)
      else $error("stop bit too short");
endmodule : uabw_checker

// ### verilog/uabw_defs.svh
// Offsets, field positions, reset values and counts of the autobaud/wake/break logic
`ifndef UABW_DEFS_SVH
`define UABW_DEFS_SVH

// ****************************************
// Device register offsets
// ****************************************
`define UABW_DEV_CTRL      12'h000
`define UABW_DEV_DIV       12'h004
`define UABW_DEV_RXDATA    12'h008
`define UABW_DEV_TXDATA    12'h00C

// ****************************************
// Device control and status bit positions
// ****************************************
`define UABW_B_CAL         0
`define UABW_B_WAKE        1
`define UABW_B_BRK         2
`define UABW_B_TXON        3
`define UABW_B_WIDE        4
`define UABW_B_HSPD        5
`define UABW_B_OVF         6
`define UABW_B_IDLE        7
`define UABW_B_RIF         8
`define UABW_B_TRMT        9

// ****************************************
// Device values and counts
// ****************************************
`define UABW_DIV_RST       16'h0000
`define UABW_CAL_FIRST     16'h0001
`define UABW_CAL_LAST_RISE 3'h4
`define UABW_MASK_64       9'h03F
`define UABW_MASK_16       9'h00F
`define UABW_MASK_4        9'h003
`define UABW_BRK_FRAME     14'h2000
`define UABW_BRK_BITS      4'hE
`define UABW_BYTE_BITS     4'hA

// ****************************************
// Remote node register offsets and values
// ****************************************
`define UABW_NODE_CMD      12'h000
`define UABW_NODE_BIT      12'h004
`define UABW_NODE_STAT     12'h008
`define UABW_NODE_BIT_RST  16'h0064
`define UABW_NODE_OP_BYTE  0
`define UABW_NODE_OP_BRK   1

`endif

// ### verilog/uabw_dev.sv
// Serial transceiver extension: autobaud measurement, wake on break, break transmit
// Operation
// - Start bit begins calibration, receiver held idle
// - Remote sends 55h, five rising edges
// - Count from first rise to fifth rise
// - Fifth rise: keep count, clear start, flag
// - Data register read clears receive flag
// - Both divider bytes form one counter
// - Counter ticks at base clock over eight
// - Counter starts at one; software subtracts one
// - Wake plus autobaud: measure character after break
// - Counter overflow sets overflow and receive flag
// - Counting continues; idle low until fifth rise
// - Early stop: remaining falls become start bits
// - Software clears overflow after idle returns
// - Wake enable holds receiver idle, watching line
// - Falling receive line is wake event, flag
// - Data register read clears wake flag
// - Rising edge after break clears wake enable
// - Nonzero character: first low time wakes
// - Wake character all zeros, ten bits minimum
// - Software checks idle before enabling wake
// - Break is start, twelve zeros, stop
// - Next data write with break bit sends zeros
// - Break bit clears after stop; next byte follows
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "uabw_defs.svh"
module uabw_dev
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Power state and flags
   input  wire logic        sleep_mode,
   output logic             rx_flag,
   output logic             wake_async,
   // Link
   uabw_link_if.dev         link
);

   uabw_pkg::uabw_dev_st_t st_ff;
   uabw_pkg::uabw_dev_st_t nxt_st;

   logic       acc;
   logic       wr_acc;
   logic       rd_rx;
   logic       fall;
   logic       rise;
   logic       base_tick;
   logic       cal_tick;
   logic       bit_tick;
   logic       rx_idle;
   logic       trmt;
   logic [8:0] bmask;

   // ****************************************
   // Decoding
   // ****************************************
   function automatic logic [8:0] base_mask(input logic wide, input logic hspd);
      case ({wide, hspd})
         2'b00:   base_mask = `UABW_MASK_64;
         2'b11:   base_mask = `UABW_MASK_4;
         default: base_mask = `UABW_MASK_16;
      endcase
   endfunction : base_mask

   assign acc       = psel & penable & st_ff.pready;
   assign wr_acc    = acc & pwrite;
   assign rd_rx     = acc & ~pwrite & (paddr == `UABW_DEV_RXDATA);
   assign fall      = st_ff.rx_s3 & ~st_ff.rx_s2;
   assign rise      = ~st_ff.rx_s3 & st_ff.rx_s2;
   assign bmask     = base_mask(st_ff.wide, st_ff.hspd);
   assign base_tick = (st_ff.pre & bmask) == bmask;
   assign cal_tick  = (st_ff.pre & {bmask[5:0], 3'h7}) == {bmask[5:0], 3'h7};
   // At least, not equal: a divider written below the running count must not stall bits
   assign bit_tick  = base_tick & (st_ff.bd >= st_ff.div);
   assign rx_idle   = (st_ff.ab == uabw_pkg::UABW_AB_IDLE)
                    | (st_ff.ab == uabw_pkg::UABW_AB_START);
   assign trmt      = (st_ff.tx == uabw_pkg::UABW_TX_IDLE) & ~st_ff.buf_v;

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      nxt_st        = st_ff;
      nxt_st.rx_s1  = link.rx_line;
      nxt_st.rx_s2  = st_ff.rx_s1;
      nxt_st.rx_s3  = st_ff.rx_s2;
      nxt_st.pre    = st_ff.pre + 9'h001;
      nxt_st.pready = psel & ~penable;

      // Register reads answer one cycle after setup
      if (psel & ~penable)
      begin
         nxt_st.pslverr = 1'b0;
         case (paddr)
            `UABW_DEV_CTRL:
               nxt_st.prdata = {22'h000000, trmt, st_ff.rif, rx_idle, st_ff.ovf,
                                st_ff.hspd, st_ff.wide, st_ff.tx_on, st_ff.brk,
                                st_ff.wake, st_ff.cal_go};
            `UABW_DEV_DIV:    nxt_st.prdata = {16'h0000, st_ff.div};
            `UABW_DEV_RXDATA: nxt_st.prdata = 32'h00000000;
            `UABW_DEV_TXDATA: nxt_st.prdata = 32'h00000000;
            default:
            begin
               nxt_st.prdata  = 32'h00000000;
               nxt_st.pslverr = 1'b1;
            end
         endcase
      end

      // Software writes; hardware events below override them
      if (wr_acc && paddr == `UABW_DEV_CTRL)
      begin
         nxt_st.cal_go = pwdata[`UABW_B_CAL];
         nxt_st.wake   = pwdata[`UABW_B_WAKE];
         nxt_st.brk    = pwdata[`UABW_B_BRK];
         nxt_st.tx_on  = pwdata[`UABW_B_TXON];
         nxt_st.wide   = pwdata[`UABW_B_WIDE];
         nxt_st.hspd   = pwdata[`UABW_B_HSPD];
         nxt_st.ovf    = st_ff.ovf & pwdata[`UABW_B_OVF];
      end
      if (wr_acc && paddr == `UABW_DEV_DIV)
         nxt_st.div = pwdata[15:0];
      if (rd_rx)
         nxt_st.rif = 1'b0;

      // Divider counts base ticks for bit timing, during calibration too
      if (bit_tick)
         nxt_st.bd = 16'h0000;
      else if (base_tick)
         nxt_st.bd = st_ff.bd + 16'h0001;

      // Wake on break; receiver stays idle meanwhile
      if (st_ff.wake)
      begin
         if (fall)
            nxt_st.rif = 1'b1;
         if (rise)
            nxt_st.wake = 1'b0;
      end

      // Autobaud sequence
      case (st_ff.ab)
         uabw_pkg::UABW_AB_IDLE:
            if (st_ff.cal_go)
               nxt_st.ab = uabw_pkg::UABW_AB_START;
         uabw_pkg::UABW_AB_START:
            if (st_ff.cal_go && !st_ff.wake && fall)
               nxt_st.ab = uabw_pkg::UABW_AB_RISE;
         uabw_pkg::UABW_AB_RISE:
            if (rise)
            begin
               nxt_st.div  = `UABW_CAL_FIRST;
               nxt_st.rise = 3'h0;
               nxt_st.ab   = uabw_pkg::UABW_AB_COUNT;
            end
         uabw_pkg::UABW_AB_COUNT:
         begin
            if (cal_tick)
            begin
               nxt_st.div = st_ff.div + 16'h0001;
               if (st_ff.div == 16'hFFFF)
               begin
                  nxt_st.ovf = 1'b1;
                  nxt_st.rif = 1'b1;
               end
            end
            if (rise)
            begin
               nxt_st.rise = st_ff.rise + 3'h1;
               if (st_ff.rise == `UABW_CAL_LAST_RISE - 3'h1)
               begin
                  // Count is left in the divider as the bit period
                  nxt_st.div = st_ff.div;
                  nxt_st.cal_go = 1'b0;
                  nxt_st.rif = 1'b1;
                  nxt_st.ab  = uabw_pkg::UABW_AB_IDLE;
               end
            end
         end
         default: nxt_st.ab = uabw_pkg::UABW_AB_IDLE;
      endcase
      // Early abort leaves the rest of the character to the receiver
      if (!st_ff.cal_go && st_ff.ab != uabw_pkg::UABW_AB_IDLE)
         nxt_st.ab = uabw_pkg::UABW_AB_IDLE;

      // Transmit holding buffer; a full buffer ignores writes
      if (wr_acc && paddr == `UABW_DEV_TXDATA && !st_ff.buf_v)
      begin
         nxt_st.buf_v   = 1'b1;
         nxt_st.buf_d   = pwdata[7:0];
         nxt_st.buf_brk = st_ff.brk & st_ff.tx_on
                        & ~((st_ff.tx == uabw_pkg::UABW_TX_SHIFT) & st_ff.tx_brk);
      end

      // Transmit shifter
      case (st_ff.tx)
         uabw_pkg::UABW_TX_IDLE:
         begin
            nxt_st.tx_line = 1'b1;
            if (st_ff.buf_v && st_ff.tx_on && bit_tick)
            begin
               nxt_st.buf_v  = 1'b0;
               nxt_st.tx_brk = st_ff.buf_brk;
               nxt_st.tx     = uabw_pkg::UABW_TX_SHIFT;
               if (st_ff.buf_brk)
               begin
                  // Written value dropped: start, twelve zeros, stop
                  nxt_st.sh    = `UABW_BRK_FRAME;
                  nxt_st.nbits = `UABW_BRK_BITS;
               end
               else
               begin
                  nxt_st.sh    = {4'hF, 1'b1, st_ff.buf_d, 1'b0};
                  nxt_st.nbits = `UABW_BYTE_BITS;
               end
            end
         end
         uabw_pkg::UABW_TX_SHIFT:
         begin
            nxt_st.tx_line = st_ff.sh[0];
            if (bit_tick)
            begin
               nxt_st.sh    = {1'b1, st_ff.sh[13:1]};
               nxt_st.nbits = st_ff.nbits - 4'h1;
               if (st_ff.nbits == 4'h1)
               begin
                  nxt_st.tx = uabw_pkg::UABW_TX_IDLE;
                  if (st_ff.tx_brk)
                     nxt_st.brk = 1'b0;
               end
            end
         end
         default: nxt_st.tx = uabw_pkg::UABW_TX_IDLE;
      endcase
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_ff         <= '0;
         st_ff.rx_s1   <= 1'b1;
         st_ff.rx_s2   <= 1'b1;
         st_ff.rx_s3   <= 1'b1;
         st_ff.div     <= `UABW_DIV_RST;
         st_ff.ab      <= uabw_pkg::UABW_AB_IDLE;
         st_ff.tx      <= uabw_pkg::UABW_TX_IDLE;
         st_ff.tx_line <= 1'b1;
      end
      else
         st_ff <= nxt_st;
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Clockless path: pclk is stopped in sleep, so no flop may sit here
   assign wake_async   = sleep_mode & st_ff.wake & ~link.rx_line;
   assign rx_flag      = st_ff.rif;
   assign link.tx_line = st_ff.tx_line;
   assign prdata       = st_ff.prdata;
   assign pready       = st_ff.pready;
   assign pslverr      = st_ff.pslverr;

endmodule : uabw_dev

// ### verilog/uabw_link_if.sv
// Serial link between the transceiver extension and the remote node
`timescale 1ns/1ns
interface uabw_link_if;
   logic rx_line;
   logic tx_line;

   modport dev
   (
      input  rx_line,
      output tx_line
   );

   modport node
   (
      output rx_line,
      input  tx_line
   );
endinterface : uabw_link_if

// ### verilog/uabw_node.sv
// Remote serial node: sends sync bytes and break/wake characters on the receive line
`timescale 1ns/1ns
`include "uabw_defs.svh"
module uabw_node
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Link
   uabw_link_if.node        link
);

   uabw_pkg::uabw_node_st_t st_ff;
   uabw_pkg::uabw_node_st_t nxt_st;

   logic       wr_acc;
   logic [4:0] brk_len;

   assign wr_acc  = psel & penable & st_ff.pready & pwrite;
   assign brk_len = pwdata[20:16];

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      nxt_st        = st_ff;
      nxt_st.tx_s1  = link.tx_line;
      nxt_st.tx_s2  = st_ff.tx_s1;
      nxt_st.pready = psel & ~penable;
      if (psel & ~penable)
      begin
         nxt_st.pslverr = 1'b0;
         case (paddr)
            `UABW_NODE_CMD:  nxt_st.prdata = 32'h00000000;
            `UABW_NODE_BIT:  nxt_st.prdata = {16'h0000, st_ff.bit_len};
            `UABW_NODE_STAT: nxt_st.prdata = {30'h00000000, st_ff.tx_s2,
                                              st_ff.tx == uabw_pkg::UABW_TX_SHIFT};
            default:
            begin
               nxt_st.prdata  = 32'h00000000;
               nxt_st.pslverr = 1'b1;
            end
         endcase
      end
      if (wr_acc && paddr == `UABW_NODE_BIT)
         nxt_st.bit_len = pwdata[15:0];
      case (st_ff.tx)
         uabw_pkg::UABW_TX_IDLE:
         begin
            if (wr_acc && paddr == `UABW_NODE_CMD)
            begin
               if (pwdata[`UABW_NODE_OP_BRK])
               begin
                  // All-zero wake or break character, then the stop bit
                  nxt_st.sh    = 32'hFFFFFFFF << brk_len;
                  nxt_st.nbits = {1'b0, brk_len} + 6'h01;
                  nxt_st.tx    = uabw_pkg::UABW_TX_SHIFT;
                  nxt_st.cnt   = 16'h0000;
               end
               else if (pwdata[`UABW_NODE_OP_BYTE])
               begin
                  // Sync byte 55h is written by software like any byte
                  nxt_st.sh    = {22'h3FFFFF, 1'b1, pwdata[15:8], 1'b0};
                  nxt_st.nbits = 6'h0A;
                  nxt_st.tx    = uabw_pkg::UABW_TX_SHIFT;
                  nxt_st.cnt   = 16'h0000;
               end
            end
         end
         uabw_pkg::UABW_TX_SHIFT:
         begin
            nxt_st.line = st_ff.sh[0];
            if (st_ff.cnt >= st_ff.bit_len - 16'h0001)
            begin
               nxt_st.cnt   = 16'h0000;
               nxt_st.sh    = {1'b1, st_ff.sh[31:1]};
               nxt_st.nbits = st_ff.nbits - 6'h01;
               if (st_ff.nbits == 6'h01)
                  nxt_st.tx = uabw_pkg::UABW_TX_IDLE;
            end
            else
               nxt_st.cnt = st_ff.cnt + 16'h0001;
         end
         default: nxt_st.tx = uabw_pkg::UABW_TX_IDLE;
      endcase
      if (st_ff.tx != uabw_pkg::UABW_TX_SHIFT)
         nxt_st.line = 1'b1;
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_ff         <= '0;
         st_ff.bit_len <= `UABW_NODE_BIT_RST;
         st_ff.tx      <= uabw_pkg::UABW_TX_IDLE;
         st_ff.tx_s1   <= 1'b1;
         st_ff.tx_s2   <= 1'b1;
         st_ff.line    <= 1'b1;
      end
      else
         st_ff <= nxt_st;
   end

   assign link.rx_line = st_ff.line;
   assign prdata       = st_ff.prdata;
   assign pready       = st_ff.pready;
   assign pslverr      = st_ff.pslverr;

endmodule : uabw_node

// ### verilog/uabw_pkg.sv
// Types shared by both ends of the autobaud/wake/break link
package uabw_pkg;

   // ****************************************
   // State encodings
   // ****************************************
   typedef enum logic [3:0]
   {
      UABW_AB_IDLE  = 4'h1,
      UABW_AB_START = 4'h2,
      UABW_AB_RISE  = 4'h4,
      UABW_AB_COUNT = 4'h8
   } uabw_ab_state_t;

   typedef enum logic [1:0]
   {
      UABW_TX_IDLE  = 2'h1,
      UABW_TX_SHIFT = 2'h2
   } uabw_tx_state_t;

   // ****************************************
   // Device state
   // ****************************************
   typedef struct packed
   {
      logic           rx_s1;
      logic           rx_s2;
      logic           rx_s3;
      logic [8:0]     pre;
      logic [15:0]    bd;
      logic           cal_go;
      logic           wake;
      logic           brk;
      logic           tx_on;
      logic           wide;
      logic           hspd;
      logic           ovf;
      logic           rif;
      logic [15:0]    div;
      uabw_ab_state_t ab;
      logic [2:0]     rise;
      uabw_tx_state_t tx;
      logic [13:0]    sh;
      logic [3:0]     nbits;
      logic           tx_brk;
      logic           buf_v;
      logic [7:0]     buf_d;
      logic           buf_brk;
      logic           tx_line;
      logic           pready;
      logic           pslverr;
      logic [31:0]    prdata;
   } uabw_dev_st_t;

   // ****************************************
   // Remote node state
   // ****************************************
   typedef struct packed
   {
      logic [15:0]    bit_len;
      logic [15:0]    cnt;
      logic [31:0]    sh;
      logic [5:0]     nbits;
      uabw_tx_state_t tx;
      logic           tx_s1;
      logic           tx_s2;
      logic           line;
      logic           pready;
      logic           pslverr;
      logic [31:0]    prdata;
   } uabw_node_st_t;

endpackage : uabw_pkg
